// ### rtl/i2c_target.sv
`timescale 1ns/1ps
`include "lux_defines.svh"

module i2c_target
  import lux_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h44
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic [7:0]       ptr,
  output logic             wr_en,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data
);

  i2c_regs_s r;
  i2c_regs_s next_r;

  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] load_byte;

  assign start_seen = r.scl_q && scl_in && r.sda_q && !sda_in;
  assign stop_seen  = r.scl_q && scl_in && !r.sda_q && sda_in;
  assign scl_rise   = !r.scl_q && scl_in;
  assign scl_fall   = r.scl_q && !scl_in;
  // high byte first; an acked read byte flips the half, taken from r so the path stays loop-free
  assign load_byte  = (r.low_byte ^ (r.st == ST_RACK)) ? rd_data[7:0] : rd_data[15:8];

  always_comb begin
    next_r       = r;
    next_r.scl_q = scl_in;
    next_r.sda_q = sda_in;
    next_r.wr_en = 1'b0;
    if (start_seen) begin
      next_r.st       = ST_ADDR;
      next_r.cnt      = `CNT_ZERO;
      next_r.low_byte = 1'b0;
      next_r.sda_oe   = 1'b0;
    end else if (stop_seen) begin
      next_r.st     = ST_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (r.st)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          next_r.shreg = {r.shreg[6:0], sda_in};
          next_r.cnt   = r.cnt + `CNT_ONE;
        end
        ST_RACK: begin
          if (sda_in) begin
            next_r.st = ST_IDLE;
          end
        end
        ST_IDLE, ST_ADDR_ACK, ST_PTR_ACK, ST_WACK, ST_RDATA: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (r.st)
        ST_ADDR: begin
          if (r.cnt == `BYTE_BITS) begin
            if (r.shreg[7:1] == DEV_ADDR) begin
              next_r.st      = ST_ADDR_ACK;
              next_r.is_read = r.shreg[0];
              next_r.sda_oe  = 1'b1;
            end else begin
              next_r.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RACK: begin
          next_r.cnt = `CNT_ZERO;
          if (r.st == ST_RACK || r.is_read) begin
            if (r.st == ST_RACK) begin
              next_r.low_byte = !r.low_byte;
            end
            next_r.st     = ST_RDATA;
            next_r.shreg  = load_byte;
            next_r.sda_oe = !load_byte[7];
          end else begin
            next_r.st     = ST_PTR;
            next_r.sda_oe = 1'b0;
          end
        end
        ST_PTR: begin
          if (r.cnt == `BYTE_BITS) begin
            next_r.ptr    = r.shreg;
            next_r.st     = ST_PTR_ACK;
            next_r.sda_oe = 1'b1;
          end
        end
        ST_PTR_ACK, ST_WACK: begin
          next_r.st     = ST_WDATA;
          next_r.cnt    = `CNT_ZERO;
          next_r.sda_oe = 1'b0;
          if (r.st == ST_WACK) begin
            next_r.low_byte = !r.low_byte;
          end
        end
        ST_WDATA: begin
          if (r.cnt == `BYTE_BITS) begin
            next_r.st     = ST_WACK;
            next_r.sda_oe = 1'b1;
            if (r.low_byte) begin
              next_r.wr_en   = 1'b1;
              next_r.wr_data = {r.wbuf, r.shreg};
            end else begin
              next_r.wbuf = r.shreg;
            end
          end
        end
        ST_RDATA: begin
          if (r.cnt == `LAST_RD_SHIFT) begin
            next_r.st     = ST_RACK;
            next_r.sda_oe = 1'b0;
          end else begin
            next_r.shreg  = {r.shreg[6:0], 1'b0};
            next_r.sda_oe = !r.shreg[6];
            next_r.cnt    = r.cnt + `CNT_ONE;
          end
        end
        ST_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.scl_q   <= 1'b1;
      r.sda_q   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = r.sda_oe;
  assign ptr     = r.ptr;
  assign wr_en   = r.wr_en;
  assign wr_data = r.wr_data;

endmodule

// ### rtl/light_limit_id_registers.sv
`timescale 1ns/1ps
`include "lux_defines.svh"

// Operation
// - An upper threshold register at address 03h is read and written over I2C and bounds the comparison logic.
// - Bits 15:12 of the upper threshold hold an exponent encoded like the result exponent.
// - Bits 11:0 of the upper threshold hold an unsigned mantissa from zero to the exponent's full scale.
// - After reset the upper threshold reads BFFFh, the full mantissa at exponent Bh.
// - Exponent masking changes only the returned result value, never the comparisons.
// - Address 7Eh returns a fixed sixteen-bit maker code and ignores writes.
// - Address 7Fh returns a fixed sixteen-bit part code and ignores writes.
// - The alert pin may also announce that a new conversion sample is ready.
// - Result and both thresholds are scaled to lux before they are compared, so exponents may differ.
// - The below flag sets after the fault-count number of consecutive results under the lower threshold.
module light_limit_id_registers
  import lux_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR   = 7'h44,
  parameter logic [15:0] MAKER_CODE = 16'hA5C3,  // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0F1E   // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] result,
  input  wire logic        result_valid,
  input  wire logic [15:0] lower_limit,
  input  wire logic [1:0]  fault_count,
  input  wire logic        exponent_masking,
  input  wire logic [3:0]  range_number,
  input  wire logic        ready_alert_mode,
  input  wire logic        flag_clear,
  output logic [15:0]      masked_result,
  output logic [15:0]      upper_limit,
  output logic             above_flag,
  output logic             below_flag,
  output logic             alert_out,
  output logic             alert_oe
);

  limit_regs_s r;
  limit_regs_s next_r;

  logic [7:0]  ptr;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  logic [`LUX_W-1:0] result_lux;
  logic [`LUX_W-1:0] upper_lux;
  logic [`LUX_W-1:0] lower_lux;
  logic [3:0]        need;

  function automatic logic [`LUX_W-1:0] to_lux(input logic [15:0] v);
    logic [`LUX_W-1:0] m;
    m = {{(`LUX_W-`MANT_MSB-1){1'b0}}, v[`MANT_MSB:`MANT_LSB]};
    to_lux = m << v[`EXP_MSB:`EXP_LSB];
  endfunction

  function automatic logic [3:0] fault_need(input logic [1:0] fc);
    unique case (fc)
      `FAULT_ONE:  fault_need = `NEED_ONE;
      `FAULT_TWO:  fault_need = `NEED_TWO;
      `FAULT_FOUR: fault_need = `NEED_FOUR;
      default:     fault_need = `NEED_EIGHT;
    endcase
  endfunction

  function automatic logic [3:0] run_count(input logic hit, input logic [3:0] cnt, input logic [3:0] lim);
    if (!hit) begin
      run_count = `CNT_ZERO;
    end else if (cnt >= lim) begin
      run_count = lim;
    end else begin
      run_count = cnt + `CNT_ONE;
    end
  endfunction

  i2c_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk     (clk),
    .rst_b   (rst_b),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .ptr     (ptr),
    .wr_en   (wr_en),
    .wr_data (wr_data),
    .rd_data (rd_data)
  );

  always_comb begin
    unique case (ptr)
      `REG_UPPER_LIMIT: rd_data = r.upper;
      `REG_MAKER_ID:    rd_data = MAKER_CODE;
      `REG_PART_ID:     rd_data = PART_CODE;
      default:          rd_data = `READ_ZERO;
    endcase
  end

  // comparisons use the raw result so masking cannot hide a range change
  assign result_lux = to_lux(result);
  assign upper_lux  = to_lux(r.upper);
  assign lower_lux  = to_lux(lower_limit);
  assign need       = fault_need(fault_count);

  always_comb begin
    next_r = r;
    if (wr_en && ptr == `REG_UPPER_LIMIT) begin
      next_r.upper = wr_data;
    end
    // set wins over clear when both land in one cycle
    if (flag_clear) begin
      next_r.above_flag = 1'b0;
      next_r.below_flag = 1'b0;
      next_r.ready_flag = 1'b0;
    end
    if (result_valid) begin
      next_r.above_cnt = run_count(result_lux > upper_lux, r.above_cnt, need);
      next_r.below_cnt = run_count(result_lux < lower_lux, r.below_cnt, need);
      if (next_r.above_cnt == need) begin
        next_r.above_flag = 1'b1;
      end
      if (next_r.below_cnt == need) begin
        next_r.below_flag = 1'b1;
      end
      if (ready_alert_mode) begin
        next_r.ready_flag = 1'b1;
      end
      if (exponent_masking && range_number < `RANGE_AUTO) begin
        next_r.masked_result = {`EXP_MASKED, result[`MANT_MSB:`MANT_LSB]};
      end else begin
        next_r.masked_result = result;
      end
    end
    next_r.alert_oe = next_r.above_flag || next_r.below_flag || next_r.ready_flag;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r       <= '0;
      r.upper <= `UPPER_LIMIT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign masked_result = r.masked_result;
  assign upper_limit   = r.upper;
  assign above_flag    = r.above_flag;
  assign below_flag    = r.below_flag;
  assign alert_out     = 1'b0;
  assign alert_oe      = r.alert_oe;

endmodule

// ### shared/lux_defines.svh
`ifndef LUX_DEFINES_SVH
`define LUX_DEFINES_SVH

`define REG_UPPER_LIMIT    8'h03
`define REG_MAKER_ID       8'h7E
`define REG_PART_ID        8'h7F

`define UPPER_LIMIT_RESET  16'hBFFF
`define EXP_MSB            15
`define EXP_LSB            12
`define MANT_MSB           11
`define MANT_LSB           0
`define LUX_W              27
`define RANGE_AUTO         4'hC
`define EXP_MASKED         4'h0

`define FAULT_ONE          2'h0
`define FAULT_TWO          2'h1
`define FAULT_FOUR         2'h2
`define NEED_ONE           4'h1
`define NEED_TWO           4'h2
`define NEED_FOUR          4'h4
`define NEED_EIGHT         4'h8
`define CNT_ZERO           4'h0
`define CNT_ONE            4'h1

`define BYTE_BITS          4'h8
`define LAST_RD_SHIFT      4'h7
`define READ_ZERO          16'h0000

`endif

// ### shared/lux_pkg.sv
package lux_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } i2c_state_e;

  typedef struct packed {
    i2c_state_e  st;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic [7:0]  wbuf;
    logic        is_read;
    logic        low_byte;
    logic        scl_q;
    logic        sda_q;
    logic        sda_oe;
    logic        wr_en;
    logic [15:0] wr_data;
  } i2c_regs_s;

  typedef struct packed {
    logic [15:0] upper;
    logic [3:0]  above_cnt;
    logic [3:0]  below_cnt;
    logic        above_flag;
    logic        below_flag;
    logic        ready_flag;
    logic        alert_oe;
    logic [15:0] masked_result;
  } limit_regs_s;

endpackage

// ### verification/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h44
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // releases sda first so it also serves as a repeated start
  task automatic start();
    sda_low <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(4);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b0;
    wt(4);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
    wt(3);
  endtask
  task automatic wb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, r);
    ak = !r;
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] p, input logic [15:0] d, output logic ak);
    logic [7:0] q;
    logic       k;
    start();
    wb({ad, 1'b0}, 1'b1, q, ak);
    wb(p, 1'b1, q, k);
    wb(d[15:8], 1'b1, q, k);
    wb(d[7:0], 1'b1, q, k);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic k;
    start();
    wb({ADDR, 1'b0}, 1'b1, d[7:0], k);
    wb(p, 1'b1, d[7:0], k);
    start();
    wb({ADDR, 1'b1}, 1'b1, d[7:0], k);
    wb(8'hFF, 1'b0, d[15:8], k);
    wb(8'hFF, 1'b1, d[7:0], k);
    stop();
  endtask
endmodule

// ### verification/light_limit_checker_sva.sv
`timescale 1ns/1ps
module light_limit_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] result,
  input wire logic        result_valid,
  input wire logic [15:0] lower_limit,
  input wire logic [1:0]  fault_count,
  input wire logic        exponent_masking,
  input wire logic [3:0]  range_number,
  input wire logic        ready_alert_mode,
  input wire logic        flag_clear,
  input wire logic [15:0] masked_result,
  input wire logic [15:0] upper_limit,
  input wire logic        above_flag,
  input wire logic        below_flag,
  input wire logic        alert_oe
);
  function automatic logic [26:0] lux(input logic [15:0] v);
    return 27'(v[11:0]) << v[15:12];
  endfunction
  wire hi = lux(result) > lux(upper_limit);
  wire lo = lux(result) < lux(lower_limit);
  wire mk = exponent_masking && range_number < 4'hC;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reset_state_a: assert property ($rose(rst_b) |-> upper_limit == 16'hBFFF && !above_flag && !alert_oe)
    else $error("bad state after reset");
  above_set_a: assert property (result_valid && fault_count == 2'h0 && hi |=> above_flag)
    else $error("above flag not set");
  below_set_a: assert property (result_valid && fault_count == 2'h0 && lo |=> below_flag)
    else $error("below flag not set");
  flag_alert_a: assert property (above_flag || below_flag |-> alert_oe)
    else $error("alert idle with flag set");
  ready_alert_a: assert property (result_valid && ready_alert_mode |=> alert_oe)
    else $error("no ready alert");
  mask_on_a: assert property (result_valid && mk |=> masked_result == {4'h0, $past(result[11:0])})
    else $error("masked result wrong");
  mask_off_a: assert property (result_valid && !mk |=> masked_result == $past(result))
    else $error("unmasked result wrong");
  flag_clear_a: assert property (flag_clear && !result_valid |=> !above_flag && !below_flag)
    else $error("flags not cleared");
  cover property (result_valid ##1 $rose(above_flag));
  cover property (result_valid ##1 $rose(below_flag));
  cover property (result_valid && mk);
endmodule

bind light_limit_id_registers light_limit_checker u_light_limit_checker (
  .clk, .rst_b, .result, .result_valid, .lower_limit, .fault_count, .exponent_masking, .range_number,
  .ready_alert_mode, .flag_clear, .masked_result, .upper_limit, .above_flag, .below_flag, .alert_oe
);

// ### verification/tb_light_limit_id_registers.sv
`timescale 1ns/1ps
`include "lux_defines.svh"
module tb_light_limit_id_registers;
  localparam logic [15:0] MK = 16'h3C5A;  // arbitrary value
  localparam logic [15:0] PT = 16'h7B21;  // arbitrary value
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        scl, sda_low;
  logic [15:0] result = 16'h0000;
  logic        result_valid = 1'b0;
  logic [15:0] lower_limit = 16'h0000;
  logic [1:0]  fault_count = 2'h0;
  logic        exponent_masking = 1'b0;
  logic [3:0]  range_number = 4'h0;
  logic        ready_alert_mode = 1'b0;
  logic        flag_clear = 1'b0;
  logic [15:0] masked_result, upper_limit, d, up;
  logic        above_flag, below_flag, alert_out, alert_oe, sda_out, sda_oe, ak;
  bit          ea, eb, er;
  int          ca, cb, bad_count, checks_done, cyc;
  wire         sda = !(sda_low || sda_oe);
  light_limit_id_registers #(.MAKER_CODE(MK), .PART_CODE(PT)) u_light_limit_id_registers (
    .clk, .rst_b, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .result, .result_valid,
    .lower_limit, .fault_count, .exponent_masking, .range_number, .ready_alert_mode,
    .flag_clear, .masked_result, .upper_limit, .above_flag, .below_flag, .alert_out, .alert_oe
  );
  i2c_host_model u_i2c_host_model (.clk, .sda, .scl, .sda_low);
  always #5 clk = ~clk;
  function automatic logic [26:0] lux(input logic [15:0] v);
    return 27'(v[11:0]) << v[15:12];
  endfunction
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conv(input logic [15:0] r);
    logic m;
    int   need;
    result <= r;
    result_valid <= 1'b1;
    exponent_masking <= 1'($urandom);
    range_number <= 4'($urandom);
    ready_alert_mode <= 1'($urandom);
    @(posedge clk);
    result_valid <= 1'b0;
    // one edge later the registered answer stands still, so inputs stay on clock edges
    @(posedge clk);
    m = exponent_masking && range_number < 4'hC;
    need = 1 << fault_count;
    ca = lux(r) > lux(up) ? (ca < need ? ca + 1 : ca) : 0;
    cb = lux(r) < lux(lower_limit) ? (cb < need ? cb + 1 : cb) : 0;
    ea |= ca == need;
    eb |= cb == need;
    er |= ready_alert_mode;
    chk("above", 16'(above_flag), 16'(ea));
    chk("below", 16'(below_flag), 16'(eb));
    chk("alert", 16'(alert_oe), 16'(ea | eb | er));
    chk("masked", masked_result, m ? {4'h0, r[11:0]} : r);
  endtask
  // a result between the limits first, so no hit count survives the clear
  task automatic clr();
    conv({4'h1, 12'hC00});
    flag_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    @(posedge clk);
    {ea, eb, er} = 3'b000;
    chk("clear", 16'({above_flag, below_flag, alert_oe}), 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h56D0));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk("upper_rst", upper_limit, `UPPER_LIMIT_RESET);
    chk("pin_levels", 16'({sda_out, alert_out}), 16'h0000);
    u_i2c_host_model.rd(`REG_UPPER_LIMIT, d);
    chk("upper_rd_rst", d, 16'hBFFF);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      up = i == 0 ? 16'h0000 : 16'($urandom);
      u_i2c_host_model.wr(7'h44, `REG_UPPER_LIMIT, up, ak);
      chk("ack", 16'(ak), 16'h0001);
      chk("upper_port", upper_limit, up);
      u_i2c_host_model.rd(`REG_UPPER_LIMIT, d);
      chk("upper_rd", d, up);
    end
    u_i2c_host_model.wr(7'h45, `REG_UPPER_LIMIT, ~up, ak);
    chk("foreign_ack", 16'(ak), 16'h0000);
    chk("upper_kept", upper_limit, up);
    for (int i = 0; i < 2; i++) begin
      u_i2c_host_model.wr(7'h44, i ? `REG_PART_ID : `REG_MAKER_ID, 16'hFFFF, ak);
      u_i2c_host_model.rd(i ? `REG_PART_ID : `REG_MAKER_ID, d);
      chk("ident", d, i ? PT : MK);
      chk("upper_after_id", upper_limit, up);
    end
    $display("test registers done");
    lower_limit <= {4'h1, 12'h800};
    up = {4'h2, 12'h800};
    u_i2c_host_model.wr(7'h44, `REG_UPPER_LIMIT, up, ak);
    for (int f = 0; f < 4; f++) begin
      fault_count <= 2'(f);
      clr();
      conv({4'h3, 12'h400});
      repeat (1 << f) conv({4'h3, 12'hFFF});
      repeat (1 << f) conv({4'h0, 12'h001});
      repeat (16) conv({2'b00, 2'($urandom), 12'($urandom)});
      $display("test fault count %0d done", f);
    end
    conclude();
  end
endmodule
